// [gpp_top.sv]
// general purpose port bank: registers, pin control and pin configuration
`timescale 1ns/1ps
module gpp_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [gpp_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [gpp_pkg::PIN_COUNT-1:0] pin_in,
   output logic [gpp_pkg::PIN_COUNT-1:0] pin_out,
   output logic [gpp_pkg::PIN_COUNT-1:0] pin_oe,
   input wire logic [gpp_pkg::PIN_COUNT-1:0] periph_oe,
   input wire logic [gpp_pkg::PIN_COUNT-1:0] periph_out,
   output logic [gpp_pkg::PIN_COUNT-1:0] pullup_en,
   output logic [gpp_pkg::PIN_COUNT-1:0] drive_high,
   output logic [2*gpp_pkg::NUM_PORTS-1:0] threshold_sel,
   input wire logic main_osc_used,
   input wire logic sub_osc_used,
   input wire logic analog_used
);
   import gpp_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   logic [4:0][7:0] dir; // port_direction_reg per port
   logic [4:0][7:0] latch; // port_data_reg latch per port
   logic [7:0] pur_lo; // pullup_select_reg_lo
   logic [7:0] pur_hi; // pullup_select_reg_hi
   logic [7:0] drv_p1; // drive_select_port1
   logic [7:0] drv_p2; // drive_select_port2
   logic [7:0] drv_glo; // drive_select_group_lo
   logic [7:0] drv_ghi; // drive_select_group_hi
   logic [7:0] thr_lo; // threshold_select_lo
   logic [7:0] thr_hi; // threshold_select_hi
   logic [4:0][7:0] next_dir;
   logic [4:0][7:0] next_latch;
   logic [7:0] next_pur_lo;
   logic [7:0] next_pur_hi;
   logic [7:0] next_drv_p1;
   logic [7:0] next_drv_p2;
   logic [7:0] next_drv_glo;
   logic [7:0] next_drv_ghi;
   logic [7:0] next_thr_lo;
   logic [7:0] next_thr_hi;
   logic [7:0] next_rdata;

   // ****************************************************************
   // derived signals
   // ****************************************************************
   logic [4:0] data_hit; // one-hot data register select
   logic [4:0] dir_hit; // one-hot direction register select
   logic armed; // port 0 direction write allowed
   logic osc_free; // both oscillators unused
   logic [4:0][7:0] out_mask; // pins able to drive now
   logic [4:0][7:0] in_mask; // pins readable now
   logic [4:0][7:0] rd_val; // data read value from each bank
   logic [4:0][7:0] pull_grp; // pull-up group select spread to pins
   logic [4:0][7:0] drv_sel; // drive select spread to pins

   // ****************************************************************
   // decoding
   // ****************************************************************
   // one-hot match of the address against a table of port offsets
   function automatic logic [4:0] port_hit(input logic [15:0] a,
                                            input logic [4:0][15:0] tbl);
      logic [4:0] hit;
      hit = 5'h00;
      for (int k = 0; k < NUM_PORTS; k++) begin
         hit[k] = (a == tbl[k]);
      end
      return hit;
   endfunction

   // reserved code 2'b11 falls back to mid threshold so the pad is never undefined
   function automatic logic [1:0] thr_decode(input logic [1:0] code);
      logic [1:0] res;
      case (code)
         GPP_THR_035: res = GPP_THR_035;
         GPP_THR_070: res = GPP_THR_070;
         default: res = GPP_THR_050;
      endcase
      return res;
   endfunction

   assign data_hit = port_hit(addr, DATA_ADDR);
   assign dir_hit = port_hit(addr, DIR_ADDR);

   // ****************************************************************
   // pin availability
   // ****************************************************************
   assign osc_free = !main_osc_used && !sub_osc_used;

   // shared pins lose their port function while their circuits run
   always_comb begin
      out_mask = DIR_MASK;
      in_mask = DATA_MASK;
      if (!osc_free) begin
         out_mask[SHARED_PORT][MAIN_OSC_BIT] = 1'b0;
         out_mask[SHARED_PORT][SUB_OSC_BIT] = 1'b0;
         in_mask[SHARED_PORT][MAIN_OSC_BIT] = 1'b0;
         in_mask[SHARED_PORT][SUB_OSC_BIT] = 1'b0;
      end
      if (analog_used) begin
         in_mask[SHARED_PORT][ANALOG_BIT] = 1'b0;
      end
   end

   // ****************************************************************
   // pin banks
   // ****************************************************************
   for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      gpp_port_if pif ();
      assign pif.dir = dir[i];
      assign pif.latch = latch[i];
      assign pif.out_mask = out_mask[i];
      assign pif.in_mask = in_mask[i];
      assign pif.periph_oe = periph_oe[i*PORT_W +: PORT_W];
      assign pif.periph_out = periph_out[i*PORT_W +: PORT_W];
      assign pif.pin_in = pin_in[i*PORT_W +: PORT_W];
      assign pin_out[i*PORT_W +: PORT_W] = pif.pin_out;
      assign pin_oe[i*PORT_W +: PORT_W] = pif.pin_oe;
      assign rd_val[i] = pif.rd_val;
      // pull-up only while the pin is an implemented input
      assign pullup_en[i*PORT_W +: PORT_W] = pull_grp[i] & ~dir[i] & out_mask[i];
      assign drive_high[i*PORT_W +: PORT_W] = drv_sel[i] & out_mask[i];
      // ports 0..2 take their code from the low register, 3..4 from the high one;
      // split per port so no out-of-range slice is ever elaborated
      if (i < 3) begin : g_thr_lo
         assign threshold_sel[2*i +: 2] = thr_decode(thr_lo[2*i +: 2]);
      end else begin : g_thr_hi
         assign threshold_sel[2*i +: 2] = thr_decode(thr_hi[2*(i-3) +: 2]);
      end
      gpp_pin_bank u_bank (
         .bus(pif)
      );
   end

   // ****************************************************************
   // group spreading for pull-up and drive
   // ****************************************************************
   // pull-up bits each cover a nibble; port 4 bits 0..3 have no pull-up
   always_comb begin
      pull_grp[0] = {{4{pur_lo[1]}}, {4{pur_lo[0]}}};
      pull_grp[1] = {{4{pur_lo[3]}}, {4{pur_lo[2]}}};
      pull_grp[2] = {4'h0, {4{pur_hi[0]}}};
      pull_grp[3] = {{4{pur_hi[2]}}, {4{pur_hi[1]}}};
      pull_grp[4] = {{4{pur_hi[3]}}, 4'h0};
      // ports 1 and 2 per bit, the others per nibble
      drv_sel[0] = {{4{drv_glo[1]}}, {4{drv_glo[0]}}};
      drv_sel[1] = drv_p1;
      drv_sel[2] = drv_p2;
      drv_sel[3] = {{4{drv_ghi[1]}}, {4{drv_ghi[0]}}};
      drv_sel[4] = {{4{drv_ghi[2]}}, 4'h0};
   end

   // ****************************************************************
   // port 0 direction write enable
   // ****************************************************************
   gpp_protect u_protect (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr(wr),
      .rd(rd),
      .prot_hit(addr == PROT_ADDR),
      .prot_bit(wdata[PROT_BIT]),
      .armed(armed)
   );

   // ****************************************************************
   // register writes and read data
   // ****************************************************************
   // next values for all registers; read data lives only in the cycle after rd
   always_comb begin
      next_dir = dir;
      next_latch = latch;
      next_pur_lo = pur_lo;
      next_pur_hi = pur_hi;
      next_drv_p1 = drv_p1;
      next_drv_p2 = drv_p2;
      next_drv_glo = drv_glo;
      next_drv_ghi = drv_ghi;
      next_thr_lo = thr_lo;
      next_thr_hi = thr_hi;
      next_rdata = 8'h00;
      for (int i = 0; i < NUM_PORTS; i++) begin
         // latch loads whatever the direction; reserved bits kept clear
         if (wr && data_hit[i]) begin
            next_latch[i] = wdata & DATA_MASK[i];
         end
         // absent direction bits are masked off
         if (wr && dir_hit[i] && (i != 0 || armed)) begin
            next_dir[i] = wdata & DIR_MASK[i];
         end
         if (rd && data_hit[i]) begin
            next_rdata = rd_val[i];
         end
         if (rd && dir_hit[i]) begin
            next_rdata = dir[i];
         end
      end
      if (wr) begin
         case (addr)
            PUR_LO_ADDR: next_pur_lo = wdata & PUR_LO_MASK;
            PUR_HI_ADDR: next_pur_hi = wdata & PUR_HI_MASK;
            DRV_P1_ADDR: next_drv_p1 = wdata;
            DRV_P2_ADDR: next_drv_p2 = wdata & DRV_P2_MASK;
            DRV_GLO_ADDR: next_drv_glo = wdata & DRV_GLO_MASK;
            DRV_GHI_ADDR: next_drv_ghi = wdata & DRV_GHI_MASK;
            THR_LO_ADDR: next_thr_lo = wdata & THR_LO_MASK;
            THR_HI_ADDR: next_thr_hi = wdata & THR_HI_MASK;
            default: begin
               // data, direction and protect offsets are handled above
            end
         endcase
      end
      if (rd) begin
         case (addr)
            PUR_LO_ADDR: next_rdata = pur_lo;
            PUR_HI_ADDR: next_rdata = pur_hi;
            DRV_P1_ADDR: next_rdata = drv_p1;
            DRV_P2_ADDR: next_rdata = drv_p2;
            DRV_GLO_ADDR: next_rdata = drv_glo;
            DRV_GHI_ADDR: next_rdata = drv_ghi;
            THR_LO_ADDR: next_rdata = thr_lo;
            THR_HI_ADDR: next_rdata = thr_hi;
            PROT_ADDR: next_rdata = {5'h00, armed, 2'h0};
            default: begin
               // ports handled above, unmapped reads stay zero
            end
         endcase
      end
   end

   // registers; the latch is cleared too although software must not rely on it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dir <= {NUM_PORTS{REG_RESET}};
         latch <= {NUM_PORTS{REG_RESET}};
         pur_lo <= REG_RESET;
         pur_hi <= REG_RESET;
         drv_p1 <= REG_RESET;
         drv_p2 <= REG_RESET;
         drv_glo <= REG_RESET;
         drv_ghi <= REG_RESET;
         thr_lo <= REG_RESET;
         thr_hi <= REG_RESET;
         rdata <= REG_RESET;
      end else begin
         dir <= next_dir;
         latch <= next_latch;
         pur_lo <= next_pur_lo;
         pur_hi <= next_pur_hi;
         drv_p1 <= next_drv_p1;
         drv_p2 <= next_drv_p2;
         drv_glo <= next_drv_glo;
         drv_ghi <= next_drv_ghi;
         thr_lo <= next_thr_lo;
         thr_hi <= next_thr_hi;
         rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // reset is the trigger here, so the default disable must not apply
   a_dir_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> dir == '0)
      else $error("direction not cleared by reset");

   a_read_mux_sel: assert property (
      rd && addr == DATA_ADDR[0] |=> rdata == $past(rd_val[0]))
      else $error("data read did not return the selected value");

   a_latch_write_any: assert property (
      wr && addr == DATA_ADDR[1] |=> latch[1] == $past(wdata))
      else $error("port latch not loaded");

   a_output_drives_latch: assert property (dir[0][0] && !periph_oe[0]
                                          |-> pin_oe[0] && pin_out[0] == latch[0][0])
      else $error("output pin not driving the latch");

   a_periph_wins_pin: assert property (
      periph_oe[8] |-> pin_oe[8] && pin_out[8] == periph_out[8])
      else $error("peripheral output not on pin");

   a_pullup_input_only: assert property (pullup_en[0] |-> !dir[0][0] && pur_lo[0])
      else $error("pull-up on an output pin");

   a_analog_in_only: assert property (
      !pin_oe[34] && !pullup_en[34] && !drive_high[34])
      else $error("analog pin acting as output");

   a_osc_pins_off: assert property (!osc_free |-> !pin_oe[38] && !pin_oe[39])
      else $error("oscillator pin driven while oscillator used");

   a_p4_dir_absent: assert property (
      wr && addr == DIR_ADDR[4] |=> dir[4][4:0] == 5'h00)
      else $error("absent port 4 direction bits stored");

   a_dir0_protected: assert property (
      wr && addr == DIR_ADDR[0] && !armed |=> $stable(dir[0]))
      else $error("port 0 direction written without enable");

   a_reserved_zero: assert property (
      rd && addr == DIR_ADDR[2] |=> rdata[7:3] == 5'h00)
      else $error("reserved direction bits read non-zero");
endmodule

// [gpp_pkg.sv]
// package of constants and types for the general purpose port bank
package gpp_pkg;

   // ****************************************************************
   // geometry
   // ****************************************************************
   localparam int NUM_PORTS = 5; // ports 0..4
   localparam int PORT_W = 8; // bits per port register
   localparam int ADDR_W = 16; // register address width
   localparam int PIN_COUNT = NUM_PORTS * PORT_W; // flat pin vector width

   // ****************************************************************
   // register offsets, index i is the port number
   // ****************************************************************
   localparam logic [4:0][15:0] DATA_ADDR = {16'h00e8, 16'h00e5, 16'h00e4, 16'h00e1, 16'h00e0};
   localparam logic [4:0][15:0] DIR_ADDR = {16'h00ea, 16'h00e7, 16'h00e6, 16'h00e3, 16'h00e2};
   localparam logic [15:0] PUR_LO_ADDR = 16'h00f0; // pullup_select_reg_lo
   localparam logic [15:0] PUR_HI_ADDR = 16'h00f1; // pullup_select_reg_hi
   localparam logic [15:0] DRV_P1_ADDR = 16'h00f2; // drive_select_port1
   localparam logic [15:0] DRV_P2_ADDR = 16'h00f3; // drive_select_port2
   localparam logic [15:0] DRV_GLO_ADDR = 16'h00f4; // drive_select_group_lo
   localparam logic [15:0] DRV_GHI_ADDR = 16'h00f5; // drive_select_group_hi
   localparam logic [15:0] THR_LO_ADDR = 16'h00f6; // threshold_select_lo
   localparam logic [15:0] THR_HI_ADDR = 16'h00f7; // threshold_select_hi
   localparam logic [15:0] PROT_ADDR = 16'h00f8; // holds the port 0 direction write enable

   // ****************************************************************
   // implemented bits and field layouts
   // ****************************************************************
   localparam logic [4:0][7:0] DIR_MASK = {8'he0, 8'hba, 8'h07, 8'hff, 8'hff};
   localparam logic [4:0][7:0] DATA_MASK = {8'he4, 8'hba, 8'h07, 8'hff, 8'hff};
   localparam logic [7:0] PUR_LO_MASK = 8'h0f;
   localparam logic [7:0] PUR_HI_MASK = 8'h0f;
   localparam logic [7:0] DRV_P2_MASK = 8'h07;
   localparam logic [7:0] DRV_GLO_MASK = 8'h03;
   localparam logic [7:0] DRV_GHI_MASK = 8'h07;
   localparam logic [7:0] THR_LO_MASK = 8'h3f;
   localparam logic [7:0] THR_HI_MASK = 8'h0f;
   localparam int PROT_BIT = 2; // port0_direction_write_protect_bit position
   localparam int SHARED_PORT = 4; // port with analog and oscillator pins
   localparam int ANALOG_BIT = 2; // analog_shared_input_pin
   localparam int MAIN_OSC_BIT = 6; // main_osc_shared_pin
   localparam int SUB_OSC_BIT = 7; // sub_osc_shared_pin
   localparam logic [7:0] REG_RESET = 8'h00; // every register after reset

   // input threshold codes
   typedef enum logic [1:0] {
      GPP_THR_035 = 2'b00,
      GPP_THR_050 = 2'b01,
      GPP_THR_070 = 2'b10
   } gpp_thr_t;

endpackage

// [gpp_port_if.sv]
// interface carrying one port's control and pin signals to its pin bank
`timescale 1ns/1ps
interface gpp_port_if;
   logic [7:0] dir; // direction, 1 = output
   logic [7:0] latch; // port latch
   logic [7:0] out_mask; // pins allowed to drive
   logic [7:0] in_mask; // pins whose level may be read
   logic [7:0] periph_oe; // peripheral output takes the pin
   logic [7:0] periph_out; // peripheral output level
   logic [7:0] pin_in; // live pin level
   logic [7:0] pin_out; // level driven on the pin
   logic [7:0] pin_oe; // pin driven
   logic [7:0] rd_val; // value a data read returns
   modport ctrl (output dir, latch, out_mask, in_mask, periph_oe, periph_out, pin_in,
                 input pin_out, pin_oe, rd_val);
   modport bank (input dir, latch, out_mask, in_mask, periph_oe, periph_out, pin_in,
                 output pin_out, pin_oe, rd_val);
endinterface

// [gpp_pin_bank.sv]
// pin drivers and read-back selection for one eight-bit port
`timescale 1ns/1ps
module gpp_pin_bank (
   gpp_port_if.bank bus
);
   import gpp_pkg::*;

   // ****************************************************************
   // per-pin cells
   // ****************************************************************
   for (genvar j = 0; j < PORT_W; j++) begin : g_pin
      // peripheral output drives regardless of direction bit
      assign bus.pin_oe[j] = bus.out_mask[j] & (bus.periph_oe[j] | bus.dir[j]);
      // idle pins show low so nothing floats inside the design
      assign bus.pin_out[j] = bus.pin_oe[j] & (bus.periph_oe[j] ? bus.periph_out[j]
                                                                 : bus.latch[j]);
      // output mode reads the latch, input mode the pin
      assign bus.rd_val[j] = bus.in_mask[j] & ((bus.dir[j] & bus.out_mask[j]) ? bus.latch[j]
                                                                              : bus.pin_in[j]);
   end
endmodule

// [gpp_protect.sv]
// one-shot write enable for the port 0 direction register
`timescale 1ns/1ps
module gpp_protect (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr,
   input wire logic rd,
   input wire logic prot_hit,
   input wire logic prot_bit,
   output logic armed
);
   import gpp_pkg::*;

   logic next_armed; // enable for the very next access

   // ****************************************************************
   // arm on a set, spend on the following access
   // ****************************************************************
   // any strobe after arming except a protect write, which reloads it from prot_bit, consumes it, so only the next access may use it
   always_comb begin
      next_armed = armed;
      if (wr && prot_hit) begin
         next_armed = prot_bit;
      end else if (wr || rd) begin
         next_armed = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         armed <= 1'b0;
      end else begin
         armed <= next_armed;
      end
   end

   a_prot_spent: assert property (
      @(posedge clk_sys) disable iff (rst) armed && rd |=> !armed)
      else $error("protect enable survived an access");
endmodule

// [gpp_ext_dev.sv]
// outside parts wired to the port pins, and the wire level they share
`timescale 1ns/1ps
module gpp_ext_dev (
   input wire logic clk_sys,
   input wire logic [gpp_pkg::PIN_COUNT-1:0] pin_out,
   input wire logic [gpp_pkg::PIN_COUNT-1:0] pin_oe,
   input wire logic [gpp_pkg::PIN_COUNT-1:0] pullup_en,
   input wire logic [gpp_pkg::PIN_COUNT-1:0] ext_en,
   input wire logic [gpp_pkg::PIN_COUNT-1:0] ext_val,
   output logic [gpp_pkg::PIN_COUNT-1:0] pin_in
);
   import gpp_pkg::*;
   // ****************************************************************
   // wire resolution
   // ****************************************************************
   logic [PIN_COUNT-1:0] float_lvl = '0; // level seen on a line nobody holds

   // a floating line keeps changing so a stale value can never pass for a read
   always @(posedge clk_sys) begin
      float_lvl <= ~float_lvl;
   end

   // the port driver wins, then an outside part, then the pull-up
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pullup_en[i]) begin
            pin_in[i] = 1'b1; // pulled high only while nothing drives
         end else begin
            pin_in[i] = float_lvl[i];
         end
      end
   end
endmodule

// [gpp_top_test.sv]
// self-checking bench for the general purpose port bank
`timescale 1ns/1ps
module gpp_top_test;
   import gpp_pkg::*;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe, pullup_en, drive_high;
   logic [PIN_COUNT-1:0] periph_oe = '0;
   logic [PIN_COUNT-1:0] periph_out = '0;
   logic [PIN_COUNT-1:0] ext_en = '0; // lines held by outside parts
   logic [PIN_COUNT-1:0] ext_val = '0;
   logic [2*NUM_PORTS-1:0] threshold_sel;
   logic main_osc_used = 1'b0;
   logic sub_osc_used = 1'b0;
   logic analog_used = 1'b0;
   int errors = 0;
   int check_count = 0;
   logic [7:0] rv; // last value read back

   always #20 clk_sys = ~clk_sys; // 25 MHz

   gpp_top u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .periph_oe(periph_oe), .periph_out(periph_out), .pullup_en(pullup_en),
      .drive_high(drive_high), .threshold_sel(threshold_sel),
      .main_osc_used(main_osc_used), .sub_osc_used(sub_osc_used),
      .analog_used(analog_used));

   gpp_ext_dev u_ext (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic tally_and_finish;
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe; outputs are looked at in the following low phase
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(negedge clk_sys);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [15:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      rv = rdata;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      rd_reg(a);
      chk(rv, e);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic s_reset;
      for (int i = 0; i < NUM_PORTS; i++) begin
         rd_chk(DIR_ADDR[i], 8'h00);
      end
      chk(pin_oe, '0);
   endtask

   // all lines held high: absent bits must still read zero
   task automatic s_reserved;
      @(posedge clk_sys);
      ext_en <= '1;
      ext_val <= '1;
      for (int i = 1; i < NUM_PORTS; i++) begin
         rd_chk(DATA_ADDR[i], DATA_MASK[i]);
      end
      @(posedge clk_sys);
      analog_used <= 1'b1;
      rd_chk(DATA_ADDR[SHARED_PORT], 8'he0);
      @(posedge clk_sys);
      analog_used <= 1'b0;
   endtask

   task automatic s_latch;
      @(posedge clk_sys);
      ext_val[7:0] <= 8'h3c;
      wr_reg(DATA_ADDR[0], 8'h55);
      chk(pin_oe[7:0], 8'h00);
      rd_chk(DATA_ADDR[0], 8'h3c);
      wr_reg(DIR_ADDR[0], 8'h0f);
      rd_chk(DIR_ADDR[0], 8'h00);
      wr_reg(PROT_ADDR, 8'h04);
      rd_reg(PROT_ADDR);
      chk(rv, 8'h04);
      @(negedge clk_sys);
      chk(rdata, 8'h00);
      wr_reg(DIR_ADDR[0], 8'h0f);
      rd_chk(DIR_ADDR[0], 8'h00);
      wr_reg(PROT_ADDR, 8'h04);
      wr_reg(DIR_ADDR[0], 8'h0f);
      chk({pin_oe[7:0], pin_out[3:0]}, 12'h0f5);
      rd_chk(DATA_ADDR[0], 8'h35);
   endtask

   task automatic s_periph;
      wr_reg(PUR_LO_ADDR, 8'h04);
      chk(pullup_en[11:8], 4'hf);
      wr_reg(DIR_ADDR[1], 8'h01);
      chk(pullup_en[11:8], 4'he);
      @(posedge clk_sys);
      periph_oe[9] <= 1'b1; // output function on a pin left in input mode
      periph_out[9] <= 1'b1;
      @(negedge clk_sys);
      chk({pin_oe[9], pin_out[9]}, 2'b11);
      @(posedge clk_sys);
      periph_out[9] <= 1'b0;
      ext_val[10] <= 1'b0; // peripheral input pin keeps direction 0
      @(negedge clk_sys);
      chk({pin_oe[9], pin_out[9]}, 2'b10);
      rd_chk(DATA_ADDR[1], 8'hf8);
      @(posedge clk_sys);
      periph_oe <= '0;
   endtask

   task automatic s_dir_all;
      wr_reg(PROT_ADDR, 8'h04);
      for (int i = 0; i < NUM_PORTS; i++) begin
         wr_reg(DIR_ADDR[i], 8'hff);
      end
      chk(pin_oe, DIR_MASK);
      for (int i = 0; i < NUM_PORTS; i++) begin
         rd_chk(DIR_ADDR[i], DIR_MASK[i]);
      end
      // either oscillator in use takes both shared pins away
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys);
         main_osc_used <= (k == 0);
         sub_osc_used <= (k == 1);
         @(negedge clk_sys);
         chk(pin_oe, {2'b00, DIR_MASK[SHARED_PORT][5:0], DIR_MASK[3:0]});
      end
      @(posedge clk_sys);
      sub_osc_used <= 1'b0;
   endtask

   task automatic s_cfg;
      wr_reg(DRV_P1_ADDR, 8'h81);
      wr_reg(DRV_GLO_ADDR, 8'h02);
      chk(drive_high[15:0], 16'h81f0);
      wr_reg(DRV_GHI_ADDR, 8'h07);
      chk(drive_high[39:24], 16'he0ba);
      wr_reg(THR_LO_ADDR, 8'h24);
      wr_reg(THR_HI_ADDR, 8'h09);
      chk(threshold_sel,
          {GPP_THR_070, GPP_THR_050, GPP_THR_070, GPP_THR_050, GPP_THR_035});
      // the unused code falls back to the middle level
      wr_reg(THR_HI_ADDR, 8'h0f);
      chk(threshold_sel[9:6], {GPP_THR_050, GPP_THR_050});
      wr_reg(16'h00ff, 8'hff);
      rd_chk(16'h00ff, 8'h00);
   endtask

   // ****************************************************************
   // main sequence and hang guard
   // ****************************************************************
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      s_reset();
      s_reserved();
      s_latch();
      s_periph();
      s_dir_all();
      s_cfg();
      tally_and_finish();
   end

   // a run far longer than the sequence needs counts as a failure
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      tally_and_finish();
   end
endmodule
